// >>> adc_conversion_control.sv
// Converter control: clock divider, start handshake, conversion sequencer and registers
//
// Contract
// - Divider select sets converter clock rate
// - Gain 2X/4X only on channel 100
// - Sample phase four or two clocks, read-only
// - Pin-select bits route pins to analog
// - Temperature sensor follows its enable bit
// - Trim field loaded at power on
// - Unimplemented bits read as zero
// - Start high then low begins conversion
// - Start held high resets, pending cleared
// - Pending flag clears at conversion end
// - End sets interrupt flag, enable gates
// - Power-down bit disables, clears result
// - Pending high while running, resets high
// - Sample then twelve conversion clocks
// - Reference select picks supply or pin
//
// The placing of the registers and the APB interface to the registers were left to the implementer.
`timescale 1ns/10ps
`include "adc_ctrl_map.svh"

module adc_conversion_control
   import adc_ctrl_pkg::*;
(
   // Clock and reset
   input  wire logic         pclk,
   input  wire logic         presetn,
   // APB slave
   input  wire logic         psel,
   input  wire logic         penable,
   input  wire logic         pwrite,
   input  wire logic [11:0]  paddr,
   input  wire logic [31:0]  pwdata,
   output logic      [31:0]  prdata,
   output logic              pready,
   output logic              pslverr,
   // Option table trim at power on
   input  wire logic [4:0]   option_trim,
   // Analog core
   input  wire logic [11:0]  core_result,
   output analog_ctrl_t      analog_ctrl,
   output pin_route_t        pin_route,
   // Interrupt request toward the interrupt controller
   input  wire logic         converter_irq_enable,
   output logic              conv_irq_flag,
   output logic              conv_irq
);

   logic [7:0]   ctrl_first_r;
   logic [7:0]   ctrl_second_r;
   logic [7:0]   pin_select_r;
   logic [4:0]   trim_r;
   logic         trim_loaded_r;
   logic [11:0]  result_r;
   logic         pending_r;
   logic         start_prev_r;
   conv_state_t  state_r;
   logic [4:0]   phase_cnt_r;
   logic [4:0]   div_cnt_r;
   logic [4:0]   div_max;
   logic         tick;
   logic         wr_en;
   logic         rd_en;
   logic         addr_ok;
   logic         start_bit;
   logic         start_fall;
   logic         conv_done;
   logic [4:0]   smp_len;
   logic [31:0]  rdata_nxt;

   assign wr_en   = psel && penable && pwrite;
   assign rd_en   = psel && !penable && !pwrite;
   assign addr_ok = (paddr == `OFS_CTRL_FIRST) || (paddr == `OFS_CTRL_SECOND) ||
                    (paddr == `OFS_PIN_SELECT) || (paddr == `OFS_TRIM) || (paddr == `OFS_RESULT);
   assign start_bit  = ctrl_first_r[`F0_START];
   assign start_fall = start_prev_r && !start_bit;

   ////////////////////////////////////////////////////////////////////////////////
   // Registers

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_first_r <= `CTRL_FIRST_RST;
      end else if (wr_en && paddr == `OFS_CTRL_FIRST) begin
         ctrl_first_r <= {pwdata[7], 1'b0, pwdata[5:0]};
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_second_r <= `CTRL_SECOND_RST;
      end else if (wr_en && paddr == `OFS_CTRL_SECOND) begin
         // Test bit fixed at one, sample width not writable
         ctrl_second_r <= {1'b1, pwdata[6], ctrl_second_r[`F1_SMP], pwdata[4:0]};
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_select_r <= `PIN_SELECT_RST;
      end else if (wr_en && paddr == `OFS_PIN_SELECT) begin
         pin_select_r <= {pwdata[7], 5'h00, pwdata[1:0]};
      end
   end

   // Strap caught after reset release, not in the reset branch
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         trim_r        <= 5'h00;
         trim_loaded_r <= 1'b0;
      end else if (!trim_loaded_r) begin
         trim_r        <= option_trim;
         trim_loaded_r <= 1'b1;
      end else if (wr_en && paddr == `OFS_TRIM) begin
         trim_r <= pwdata[4:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Converter clock divider

   always_comb begin
      case (ctrl_second_r[2:0])
         3'h4:    div_max = 5'h00;
         3'h5:    div_max = 5'h03;
         3'h1:    div_max = 5'h07;
         3'h6:    div_max = 5'h0F;
         3'h2:    div_max = 5'h1F;
         default: div_max = 5'h01;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_cnt_r <= 5'h00;
      end else if (state_r == ST_IDLE || state_r == ST_RESET || div_cnt_r >= div_max) begin
         div_cnt_r <= 5'h00;
      end else begin
         div_cnt_r <= div_cnt_r + 5'h01;
      end
   end

   assign tick = (div_cnt_r >= div_max);

   ////////////////////////////////////////////////////////////////////////////////
   // Start handshake and sequencer

   assign smp_len   = ctrl_second_r[`F1_SMP] ? `SMP_SHORT : `SMP_LONG;
   assign conv_done = (state_r == ST_CONV) && tick && (phase_cnt_r == `CONV_CLOCKS - 5'h01);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         start_prev_r <= 1'b0;
      end else begin
         start_prev_r <= start_bit;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r     <= ST_IDLE;
         phase_cnt_r <= 5'h00;
      end else if (ctrl_first_r[`F0_PDOWN]) begin
         state_r     <= ST_IDLE;
         phase_cnt_r <= 5'h00;
      end else if (start_bit) begin
         state_r     <= ST_RESET;
         phase_cnt_r <= 5'h00;
      end else begin
         case (state_r)
            ST_RESET: begin
               state_r <= start_fall ? ST_SAMP : ST_IDLE;
            end
            ST_SAMP: begin
               if (tick) begin
                  if (phase_cnt_r == smp_len - 5'h01) begin
                     state_r     <= ST_CONV;
                     phase_cnt_r <= 5'h00;
                  end else begin
                     phase_cnt_r <= phase_cnt_r + 5'h01;
                  end
               end
            end
            ST_CONV: begin
               if (tick) begin
                  if (conv_done) begin
                     state_r     <= ST_IDLE;
                     phase_cnt_r <= 5'h00;
                  end else begin
                     phase_cnt_r <= phase_cnt_r + 5'h01;
                  end
               end
            end
            default: begin
               state_r <= ST_IDLE;
            end
         endcase
      end
   end

   // Pending flag: set by start release, cleared by reset pulse or end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pending_r <= 1'b1;
      end else if (start_bit) begin
         pending_r <= 1'b0;
      end else if (state_r == ST_RESET && start_fall && !ctrl_first_r[`F0_PDOWN]) begin
         pending_r <= 1'b1;
      end else if (conv_done) begin
         pending_r <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         result_r <= 12'h000;
      end else if (ctrl_first_r[`F0_PDOWN]) begin
         result_r <= 12'h000;
      end else if (conv_done) begin
         result_r <= core_result;
      end
   end

   // Flag held one cycle per end; controller latches it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         conv_irq_flag <= 1'b0;
         conv_irq      <= 1'b0;
      end else begin
         conv_irq_flag <= conv_done;
         conv_irq      <= conv_done && converter_irq_enable;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Analog and pin controls

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         analog_ctrl <= '0;
         pin_route   <= '0;
      end else begin
         analog_ctrl.powered      <= !ctrl_first_r[`F0_PDOWN];
         analog_ctrl.core_reset   <= (state_r == ST_RESET) || (state_r == ST_IDLE);
         analog_ctrl.sampling     <= (state_r == ST_SAMP);
         analog_ctrl.converting   <= (state_r == ST_CONV);
         analog_ctrl.conv_clk_en  <= tick && (state_r == ST_SAMP || state_r == ST_CONV);
         if (ctrl_first_r[2:0] == `CH_TEMP) begin
            analog_ctrl.gain <= ctrl_second_r[`F1_GAIN] ? GAIN_4X : GAIN_2X;
         end else begin
            analog_ctrl.gain <= GAIN_1X;
         end
         analog_ctrl.ref_from_pin       <= ctrl_second_r[`F1_VREF];
         analog_ctrl.amp_from_ldo       <= ctrl_second_r[`F1_AMP];
         analog_ctrl.high_drive         <= ctrl_first_r[`F0_MODE];
         analog_ctrl.bypass             <= ctrl_first_r[`F0_BYPASS];
         analog_ctrl.channel            <= ctrl_first_r[2:0];
         analog_ctrl.temp_sensor_on     <= pin_select_r[`FP_TS];
         analog_ctrl.bandgap_trim_field <= trim_r;
         pin_route.analog_input_1_on    <= pin_select_r[1];
         pin_route.analog_input_0_on    <= pin_select_r[0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // APB read path

   always_comb begin
      rdata_nxt = 32'h0000_0000;
      if (paddr == `OFS_CTRL_FIRST) begin
         rdata_nxt[7:0] = {ctrl_first_r[7], pending_r, ctrl_first_r[5:0]};
      end else if (paddr == `OFS_CTRL_SECOND) begin
         rdata_nxt[7:0] = ctrl_second_r;
      end else if (paddr == `OFS_PIN_SELECT) begin
         rdata_nxt[7:0] = pin_select_r;
      end else if (paddr == `OFS_TRIM) begin
         rdata_nxt[7:0] = {3'h0, trim_r};
      end else if (paddr == `OFS_RESULT) begin
         rdata_nxt[11:0] = result_r;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel && !penable;
         pslverr <= psel && !penable && !addr_ok;
         if (rd_en) begin
            prdata <= rdata_nxt;
         end
      end
   end

endmodule

// >>> adc_ctrl_map.svh
// Register offsets, field positions, reset values and timing counts of the converter control
`ifndef ADC_CTRL_MAP_SVH
`define ADC_CTRL_MAP_SVH

// Byte offsets on APB
`define OFS_CTRL_FIRST     12'h000
`define OFS_CTRL_SECOND    12'h004
`define OFS_PIN_SELECT     12'h008
`define OFS_TRIM           12'h00C
`define OFS_RESULT         12'h010

// Control-first fields
`define F0_START           7
`define F0_PENDING         6
`define F0_PDOWN           5
`define F0_MODE            4
`define F0_BYPASS          3
`define CTRL_FIRST_RST     8'h60

// Control-second fields
`define F1_TEST            7
`define F1_GAIN            6
`define F1_SMP             5
`define F1_VREF            4
`define F1_AMP             3
`define CTRL_SECOND_RST    8'h80

// Pin select fields
`define FP_TS              7
`define PIN_SELECT_RST     8'h03

// Channel code that enables pre-buffer gain
`define CH_TEMP            3'h4

// Conversion timing in converter clocks
`define SMP_LONG           5'h04
`define SMP_SHORT          5'h02
`define CONV_CLOCKS        5'h0C

`endif

// >>> adc_ctrl_pkg.sv
// Types of the converter control block
package adc_ctrl_pkg;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_RESET = 2'b01,
      ST_SAMP  = 2'b11,
      ST_CONV  = 2'b10
   } conv_state_t;

   typedef enum logic [1:0] {
      GAIN_1X = 2'b00,
      GAIN_2X = 2'b01,
      GAIN_4X = 2'b10
   } gain_t;

   typedef struct packed {
      logic        powered;
      logic        core_reset;
      logic        sampling;
      logic        converting;
      logic        conv_clk_en;
      gain_t       gain;
      logic        ref_from_pin;
      logic        amp_from_ldo;
      logic        high_drive;
      logic        bypass;
      logic [2:0]  channel;
      logic        temp_sensor_on;
      logic [4:0]  bandgap_trim_field;
   } analog_ctrl_t;

   typedef struct packed {
      logic        analog_input_1_on;
      logic        analog_input_0_on;
   } pin_route_t;

endpackage

// >>> adc_core_model.sv
// Behavioural analog converter core facing the control block
`timescale 1ns/10ps
module adc_core_model
   import adc_ctrl_pkg::*;
(
   // Control block side
   input  logic         pclk,
   input  analog_ctrl_t analog_ctrl,
   // Analog level set by the bench
   input  logic [11:0]  level,
   output logic [11:0]  core_result
);
   logic [11:0] junk_r = 12'h000;
   // Outside a conversion the output churns, so a stale capture shows up
   always_ff @(posedge pclk) begin
      junk_r <= ~junk_r ^ 12'h5A3;
   end
   assign core_result = analog_ctrl.converting ? level : junk_r;
endmodule

// >>> adc_ctrl_chk_sva.sv
// Assertions on the converter control ports
`timescale 1ns/10ps
module adc_ctrl_chk
   import adc_ctrl_pkg::*;
(
   // Clock and reset
   input logic         pclk,
   input logic         presetn,
   // Converter side
   input analog_ctrl_t analog_ctrl,
   input logic         conv_irq_flag,
   input logic         conv_irq
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_gain_unity:
      assert property (analog_ctrl.channel != 3'h4 |-> analog_ctrl.gain == GAIN_1X) else $error("gain not 1X");
   a_reset_quiet:
      assert property (analog_ctrl.core_reset |-> !analog_ctrl.sampling && !analog_ctrl.converting)
      else $error("core busy in reset");
   a_irq_gated:
      assert property (conv_irq |-> conv_irq_flag) else $error("irq without flag");
   a_flag_single:
      assert property (conv_irq_flag |=> !conv_irq_flag) else $error("flag longer than a pulse");
   a_samp_then_conv:
      assert property ($fell(analog_ctrl.sampling) && !analog_ctrl.core_reset && analog_ctrl.powered
         |-> analog_ctrl.converting) else $error("sampling not followed by conversion");
   // Flag sits on the last cycle of the registered converting level
   a_flag_at_end:
      assert property (conv_irq_flag |-> analog_ctrl.converting ##1 !analog_ctrl.converting)
      else $error("flag not at conversion end");
   a_clk_en_active:
      assert property (analog_ctrl.conv_clk_en |-> analog_ctrl.sampling || analog_ctrl.converting)
      else $error("converter clock outside activity");
   a_off_idle:
      assert property (!analog_ctrl.powered |=> !analog_ctrl.sampling && !analog_ctrl.converting)
      else $error("activity while powered down");
endmodule
bind adc_conversion_control adc_ctrl_chk chk_u (.pclk(pclk), .presetn(presetn), .analog_ctrl(analog_ctrl),
   .conv_irq_flag(conv_irq_flag), .conv_irq(conv_irq));

// >>> tb_adc_conversion_control.sv
// Testbench of the converter control block
`timescale 1ns/10ps
`include "adc_ctrl_map.svh"
module tb_adc_conversion_control
   import adc_ctrl_pkg::*;
;
   logic         pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic         irq_en, conv_irq_flag, conv_irq;
   logic [11:0]  paddr, core_result, level;
   logic [31:0]  pwdata, prdata, rd, v;
   logic [4:0]   trim;
   analog_ctrl_t ac;
   pin_route_t   pr;
   int           n_mismatch, samples_checked, n;

   adc_conversion_control dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .option_trim(trim), .core_result(core_result), .analog_ctrl(ac),
      .pin_route(pr), .converter_irq_enable(irq_en), .conv_irq_flag(conv_irq_flag), .conv_irq(conv_irq));
   adc_core_model core_u (.pclk(pclk), .analog_ctrl(ac), .level(level), .core_result(core_result));

   ////////////////////////////////////////////////////////////////////////////
   task automatic tally_and_finish();
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         n_mismatch++;
         $display("BAD %s exp %h got %h", s, e, g);
      end
   endtask
   // Request held until pready is sampled high
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   function automatic int div_of(input logic [2:0] c);
      case (c)
         3'h1: return 8;
         3'h2: return 32;
         3'h4: return 1;
         3'h5: return 4;
         3'h6: return 16;
         default: return 2;
      endcase
   endfunction
   task automatic convert(input logic [2:0] cd);
      level <= 12'($urandom);
      irq_en <= 1'($urandom);
      apb(1'b1, `OFS_CTRL_SECOND, {29'h0, cd});
      apb(1'b1, `OFS_CTRL_FIRST, 32'h80);
      apb(1'b0, `OFS_CTRL_FIRST, 32'h0);
      chk("pend_held", 32'h0, rd & 32'h40);
      apb(1'b1, `OFS_CTRL_FIRST, 32'h00);
      apb(1'b0, `OFS_CTRL_FIRST, 32'h0);
      chk("pend_run", 32'h40, rd & 32'h40);
      chk("on", 32'h1, 32'(ac.powered));
      n = 0;
      while (conv_irq_flag !== 1'b1 && n < 2000) begin
         @(posedge pclk);
         n++;
      end
      chk("span", 32'h1, 32'(n >= 15 * div_of(cd) - 4 && n <= 17 * div_of(cd) + 4));
      chk("irq", 32'(irq_en), 32'(conv_irq));
      apb(1'b0, `OFS_RESULT, 32'h0);
      chk("result", 32'(level), rd);
      chk("slverr", 32'h0, 32'(err));
      apb(1'b0, `OFS_CTRL_FIRST, 32'h0);
      chk("pend_end", 32'h0, rd & 32'h40);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end
   initial begin
      #400000;
      n_mismatch++;
      tally_and_finish();
   end
   initial begin
      n_mismatch = 0;
      samples_checked = 0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      irq_en = 1'b0;
      level = 12'h000;
      void'($urandom(32'h2BAF));
      trim = 5'($urandom);
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
      apb(1'b0, `OFS_CTRL_FIRST, 32'h0);
      chk("first_rst", 32'h60, rd);
      apb(1'b0, `OFS_TRIM, 32'h0);
      chk("trim_rst", {27'h0, trim}, rd);
      chk("bg_rst", {27'h0, trim}, 32'(ac.bandgap_trim_field));
      chk("route_rst", 32'h3, 32'(pr));
      apb(1'b1, `OFS_CTRL_SECOND, 32'h7F);
      apb(1'b0, `OFS_CTRL_SECOND, 32'h0);
      chk("second_ro", 32'hDF, rd);
      for (int i = 0; i < 4; i++) begin
         v = $urandom;
         apb(1'b1, `OFS_PIN_SELECT, v);
         apb(1'b1, `OFS_TRIM, ~v);
         apb(1'b0, `OFS_PIN_SELECT, 32'h0);
         chk("pin_rd", v & 32'h83, rd);
         chk("tsense", 32'(v[7]), 32'(ac.temp_sensor_on));
         chk("route", 32'(v[1:0]), 32'(pr));
         chk("bg_out", ~v & 32'h1F, 32'(ac.bandgap_trim_field));
         apb(1'b0, `OFS_TRIM, 32'h0);
         chk("trim_rd", ~v & 32'h1F, rd);
      end
      apb(1'b0, 12'h020, 32'h0);
      chk("unmapped", 32'h1, 32'(err));
      chk("unmapped_rd", 32'h0, rd);
      for (int i = 0; i < 16; i++) begin
         apb(1'b1, `OFS_CTRL_FIRST, 32'h20 | 32'(i[2:0]));
         apb(1'b1, `OFS_CTRL_SECOND, {25'h0, i[3], 1'b0, i[1], 4'h0});
         repeat (2) @(posedge pclk);
         chk("gain", i[2:0] != 3'h4 ? 32'(GAIN_1X) : i[3] ? 32'(GAIN_4X) : 32'(GAIN_2X), 32'(ac.gain));
         chk("chan", 32'(i[2:0]), 32'(ac.channel));
         chk("vref", 32'(i[1]), 32'(ac.ref_from_pin));
         chk("off", 32'h0, 32'(ac.powered));
      end
      apb(1'b1, `OFS_CTRL_FIRST, 32'h00);
      repeat (20) @(posedge pclk);
      // Ideal core has no period window, so every divider code is swept
      for (int c = 0; c < 8; c++) convert(3'(c));
      // Start raised again mid-run must abort
      apb(1'b1, `OFS_CTRL_FIRST, 32'h80);
      apb(1'b1, `OFS_CTRL_FIRST, 32'h00);
      apb(1'b1, `OFS_CTRL_FIRST, 32'h80);
      n = 0;
      repeat (100) begin
         @(posedge pclk);
         n += int'(conv_irq_flag === 1'b1);
      end
      chk("abort", 32'h0, 32'(n));
      apb(1'b1, `OFS_CTRL_FIRST, 32'hA0);
      apb(1'b1, `OFS_CTRL_FIRST, 32'h20);
      apb(1'b0, `OFS_CTRL_FIRST, 32'h0);
      chk("pd_start", 32'h20, rd);
      apb(1'b0, `OFS_RESULT, 32'h0);
      chk("pd_result", 32'h0, rd);
      tally_and_finish();
   end
endmodule
